// [hw/dcemu_top.sv]
// divide, compare, negate, extend, test-and-set and accumulate datapath slice
`timescale 1ns/10ps
`include "dcemu_consts.svh"
module dcemu_top import dcemu_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire dcemu_op_t i_op,
  input wire dcemu_size_t i_size,
  input wire logic i_ext_src_half,
  input wire logic [31:0] i_dst,
  input wire logic [31:0] i_src,
  output logic o_busy,
  output logic o_done,
  output logic [31:0] o_result,
  output logic o_result_we,
  output logic [3:0] o_flags,
  output logic o_flags_we,
  output logic [31:0] o_mac
);
  // ----------------------------------------------------------------
  // size helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] fit(input logic [31:0] v, input dcemu_size_t s);
    case (s)
      SZ_B: fit = {24'h0, v[7:0]};
      SZ_W: fit = {16'h0, v[15:0]};
      default: fit = v;
    endcase
  endfunction : fit

  function automatic logic [31:0] sext(input logic [31:0] v, input dcemu_size_t s);
    case (s)
      SZ_B: sext = {{24{v[7]}}, v[7:0]};
      SZ_W: sext = {{16{v[15]}}, v[15:0]};
      default: sext = v;
    endcase
  endfunction : sext

  function automatic logic sign_of(input logic [31:0] v, input dcemu_size_t s);
    case (s)
      SZ_B: sign_of = v[7];
      SZ_W: sign_of = v[15];
      default: sign_of = v[31];
    endcase
  endfunction : sign_of

  // n and z from a sized value, v and c cleared
  function automatic logic [3:0] nz_flags(input logic [31:0] v, input dcemu_size_t s);
    logic [3:0] f;
    f = 4'h0;
    f[`DCEMU_FLAG_N] = sign_of(v, s);
    f[`DCEMU_FLAG_Z] = fit(v, s) == 32'h0;
    nz_flags = f;
  endfunction : nz_flags

  // ----------------------------------------------------------------
  // op decode
  // ----------------------------------------------------------------
  dcemu_state_t state;
  logic [31:0] acc;
  logic q_neg;
  logic r_neg;
  logic div_with_rem;
  dcemu_size_t div_size;

  wire logic idle = state == ST_IDLE;
  wire logic accept = i_start && idle;
  wire logic is_unsigned_divide_with_remainder = i_op == OP_UNSIGNED_DIVIDE_WITH_REMAINDER;
  wire logic is_unsigned_divide_quotient_only = i_op == OP_UNSIGNED_DIVIDE_QUOTIENT_ONLY;
  wire logic is_signed_divide_with_remainder = i_op == OP_SIGNED_DIVIDE_WITH_REMAINDER;
  wire logic is_signed_divide_quotient_only = i_op == OP_SIGNED_DIVIDE_QUOTIENT_ONLY;
  wire logic is_div = is_unsigned_divide_with_remainder || is_unsigned_divide_quotient_only || is_signed_divide_with_remainder || is_signed_divide_quotient_only;
  wire logic with_rem = is_unsigned_divide_with_remainder || is_signed_divide_with_remainder;
  wire logic is_signed = is_signed_divide_with_remainder || is_signed_divide_quotient_only;
  wire logic is_cmp = i_op == OP_COMPARE;
  wire logic is_neg = i_op == OP_TWOS_COMPLEMENT;
  wire logic is_zero_extend_op = i_op == OP_ZERO_EXTEND;
  wire logic is_sign_extend_op = i_op == OP_SIGN_EXTEND;
  wire logic is_ext = is_zero_extend_op || is_sign_extend_op;
  wire logic is_tas = i_op == OP_TEST_AND_SET_MSB;
  wire logic is_mac = i_op == OP_MULTIPLY_ACCUMULATE;
  wire logic is_clr = i_op == OP_ACCUMULATOR_CLEAR;
  wire logic is_ldm = i_op == OP_ACCUMULATOR_LOAD;
  wire logic is_stm = i_op == OP_ACCUMULATOR_STORE;

  // ----------------------------------------------------------------
  // compare and negate share one subtractor
  // ----------------------------------------------------------------
  wire logic [31:0] sub_a = is_neg ? 32'h0 : fit(i_dst, i_size); // RULE_07
  wire logic [31:0] sub_b = fit(is_neg ? i_dst : i_src, i_size); // RULE_05
  wire logic [31:0] sub_res = sub_a - sub_b;
  wire logic [31:0] sub_fit = fit(sub_res, i_size); // RULE_07
  wire logic sub_c = sub_a < sub_b;
  wire logic sub_v = (sign_of(sub_a, i_size) != sign_of(sub_b, i_size)) &&
                     (sign_of(sub_res, i_size) != sign_of(sub_a, i_size));
  wire logic [3:0] sub_flags = nz_flags(sub_res, i_size) |
                               ({3'h0, sub_c} << `DCEMU_FLAG_C) |
                               ({3'h0, sub_v} << `DCEMU_FLAG_V); // RULE_06

  // ----------------------------------------------------------------
  // extension, test-and-set, multiply-accumulate
  // ----------------------------------------------------------------
  // a halfword source with a word result is passed through unchanged
  wire dcemu_size_t ext_from = i_ext_src_half ? SZ_W : SZ_B; // RULE_10
  wire logic [31:0] ext_zero = fit(i_dst, ext_from); // RULE_08
  wire logic [31:0] ext_sign = sext(i_dst, ext_from); // RULE_09
  wire logic [31:0] ext_res = fit(is_sign_extend_op ? ext_sign : ext_zero, i_size);
  wire logic [31:0] tas_res = {24'h0, i_dst[7:0] | `DCEMU_TAS_SET}; // RULE_11
  wire logic [3:0] tas_flags = nz_flags(i_dst, SZ_B); // RULE_11
  // operands widened first so the product keeps all 32 bits
  wire logic signed [31:0] mac_prod = 32'($signed(i_dst[15:0])) *
                                      32'($signed(i_src[15:0])); // RULE_12

  // ----------------------------------------------------------------
  // divide setup: magnitudes go to the divider, signs are kept here
  // ----------------------------------------------------------------
  wire dcemu_size_t dvd_sz = with_rem ? ((i_size == SZ_B) ? SZ_W : SZ_L) : i_size; // RULE_01
  wire dcemu_size_t dvs_sz = with_rem ? ((i_size == SZ_B) ? SZ_B : SZ_W) : i_size; // RULE_02
  wire logic [31:0] dvd_raw = is_signed ? sext(i_dst, dvd_sz) : fit(i_dst, dvd_sz);
  wire logic [31:0] dvs_raw = is_signed ? sext(i_src, dvs_sz) : fit(i_src, dvs_sz);
  wire logic dvd_neg = is_signed && dvd_raw[31]; // RULE_03
  wire logic dvs_neg = is_signed && dvs_raw[31]; // RULE_04
  wire logic [31:0] dvd_mag = dvd_neg ? 32'h0 - dvd_raw : dvd_raw;
  wire logic [31:0] dvs_mag = dvs_neg ? 32'h0 - dvs_raw : dvs_raw;
  wire logic div_zero = dvs_raw == 32'h0;
  // a zero divisor never starts the divider: the dividend stays and v is raised
  wire logic [31:0] dz_result = fit(i_dst, dvd_sz); // RULE_16
  wire logic [3:0] dz_flags = 4'h1 << `DCEMU_FLAG_V; // RULE_16

  dcemu_div_if u_div_if();

  assign u_div_if.start = accept && is_div && !div_zero;
  assign u_div_if.dividend = dvd_mag;
  assign u_div_if.divisor = dvs_mag;

  dcemu_div u_div (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .div(u_div_if.divider)
  );

  // quotient is negative when signs differ, remainder follows the dividend
  wire logic [31:0] q_fix = q_neg ? 32'h0 - u_div_if.quotient : u_div_if.quotient; // RULE_03
  wire logic [31:0] r_fix = r_neg ? 32'h0 - u_div_if.remainder : u_div_if.remainder;
  wire logic [31:0] rem_pair = (div_size == SZ_B) ? {16'h0, r_fix[7:0], q_fix[7:0]} :
                                                    {r_fix[15:0], q_fix[15:0]}; // RULE_01
  wire logic [31:0] div_result = div_with_rem ? rem_pair : fit(q_fix, div_size); // RULE_02
  wire dcemu_size_t q_sz = div_with_rem ? ((div_size == SZ_B) ? SZ_B : SZ_W) : div_size;
  wire logic [3:0] div_flags = nz_flags(q_fix, q_sz);

  // ----------------------------------------------------------------
  // one-cycle result selection
  // ----------------------------------------------------------------
  wire logic [31:0] imm_result = is_div ? dz_result :
                                 is_neg ? sub_fit :
                                 is_ext ? ext_res :
                                 is_tas ? tas_res :
                                 is_stm ? acc : 32'h0; // RULE_15
  wire logic [3:0] imm_flags = is_div ? dz_flags :
                               (is_cmp || is_neg) ? sub_flags :
                               is_ext ? nz_flags(ext_res, i_size) :
                               is_tas ? tas_flags : 4'h0;
  // compare never writes back, so its operands stay as they were
  wire logic imm_rwe = is_div || is_neg || is_ext || is_tas || is_stm; // RULE_06
  wire logic imm_fwe = is_div || is_cmp || is_neg || is_ext || is_tas;

  // ----------------------------------------------------------------
  // control
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: state <= u_div_if.start ? ST_DIV_WAIT : ST_IDLE;
        ST_DIV_WAIT: state <= u_div_if.done ? ST_IDLE : ST_DIV_WAIT;
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      q_neg <= 1'b0;
      r_neg <= 1'b0;
      div_with_rem <= 1'b0;
      div_size <= SZ_B;
    end else if (u_div_if.start) begin
      q_neg <= dvd_neg != dvs_neg;
      r_neg <= dvd_neg;
      div_with_rem <= with_rem;
      div_size <= i_size;
    end
  end

  wire logic fin_div = (state == ST_DIV_WAIT) && u_div_if.done;
  wire logic fin_imm = accept && !u_div_if.start;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_done <= 1'b0;
      o_result <= 32'h0;
      o_result_we <= 1'b0;
      o_flags <= 4'h0;
      o_flags_we <= 1'b0;
    end else begin
      o_done <= fin_div || fin_imm;
      o_result <= fin_div ? div_result : fin_imm ? imm_result : o_result;
      o_result_we <= fin_div || (fin_imm && imm_rwe);
      o_flags <= fin_div ? div_flags : (fin_imm && imm_fwe) ? imm_flags : o_flags;
      o_flags_we <= fin_div || (fin_imm && imm_fwe);
    end
  end

  // ----------------------------------------------------------------
  // accumulator
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      acc <= `DCEMU_MAC_RESET;
    end else if (accept && is_clr) begin
      acc <= 32'h0; // RULE_13
    end else if (accept && is_ldm) begin
      acc <= i_src; // RULE_14
    end else if (accept && is_mac) begin
      acc <= acc + mac_prod; // RULE_12
    end
  end

  assign o_mac = acc;
  assign o_busy = !idle;
endmodule : dcemu_top

// [hw/dcemu_consts.svh]
// constants for the divide, compare, extend and accumulate datapath slice
// Overview of operation
// RULE_01: unsigned divide 16/8 and 32/16 with remainder
// RULE_02: unsigned divide 16/16 and 32/32, quotient only
// RULE_03: signed divide 16/8 and 32/16 with remainder
// RULE_04: signed divide 16/16 and 32/32, quotient only
// RULE_05: compare subtracts source from destination, no write
// RULE_06: compare sets condition flags, operands unchanged
// RULE_07: negate gives zero minus operand, any size
// RULE_08: zero extend pads upper bits with zeros
// RULE_09: sign extend copies bit 7 or 15 upward
// RULE_10: extend byte-word, byte-long, halfword-long
// RULE_11: test byte against zero, then set bit 7
// RULE_12: accumulate signed product of two memory operands
// RULE_13: accumulator clear sets every bit to zero
// RULE_14: accumulator load copies general register in
// RULE_15: accumulator store copies out, accumulator kept
// RULE_16: zero divisor gives fixed result and flags
`ifndef DCEMU_CONSTS_SVH
`define DCEMU_CONSTS_SVH

`define DCEMU_DIV_STEPS 6'h20
`define DCEMU_FLAG_C 0
`define DCEMU_FLAG_V 1
`define DCEMU_FLAG_Z 2
`define DCEMU_FLAG_N 3
`define DCEMU_TAS_SET 8'h80
`define DCEMU_MAC_RESET 32'h0000_0000

`endif

// [hw/dcemu_pkg.sv]
// types shared by the datapath slice
package dcemu_pkg;
  typedef enum logic [3:0] {
    OP_UNSIGNED_DIVIDE_WITH_REMAINDER = 4'h0,
    OP_UNSIGNED_DIVIDE_QUOTIENT_ONLY = 4'h1,
    OP_SIGNED_DIVIDE_WITH_REMAINDER = 4'h2,
    OP_SIGNED_DIVIDE_QUOTIENT_ONLY = 4'h3,
    OP_COMPARE = 4'h4,
    OP_TWOS_COMPLEMENT = 4'h5,
    OP_ZERO_EXTEND = 4'h6,
    OP_SIGN_EXTEND = 4'h7,
    OP_TEST_AND_SET_MSB = 4'h8,
    OP_MULTIPLY_ACCUMULATE = 4'h9,
    OP_ACCUMULATOR_CLEAR = 4'ha,
    OP_ACCUMULATOR_LOAD = 4'hb,
    OP_ACCUMULATOR_STORE = 4'hc
  } dcemu_op_t;

  typedef enum logic [1:0] {
    SZ_B = 2'h0,
    SZ_W = 2'h1,
    SZ_L = 2'h2
  } dcemu_size_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'h0,
    ST_DIV_WAIT = 1'h1
  } dcemu_state_t;
endpackage : dcemu_pkg

// [hw/dcemu_div_if.sv]
// request and answer signals between the control slice and the divider
`timescale 1ns/10ps
interface dcemu_div_if;
  logic start;
  logic [31:0] dividend;
  logic [31:0] divisor;
  logic done;
  logic [31:0] quotient;
  logic [31:0] remainder;

  modport requester(output start, output dividend, output divisor,
                    input done, input quotient, input remainder);
  modport divider(input start, input dividend, input divisor,
                  output done, output quotient, output remainder);
endinterface : dcemu_div_if

// [hw/dcemu_div.sv]
// iterative unsigned 32 by 32 restoring divider
`timescale 1ns/10ps
`include "dcemu_consts.svh"
module dcemu_div import dcemu_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  dcemu_div_if.divider div
);
  // ----------------------------------------------------------------
  // one quotient bit per cycle
  // ----------------------------------------------------------------
  logic [31:0] rem;
  logic [31:0] quo;
  logic [31:0] dvs;
  logic [5:0] cnt;
  logic busy;
  logic done;

  wire logic [32:0] shifted = {rem, quo[31]};
  wire logic take = shifted >= {1'b0, dvs};
  wire logic [32:0] diff = shifted - {1'b0, dvs};

  // remainder stays below the divisor, so 32 bits always hold it
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      rem <= 32'h0;
      quo <= 32'h0;
      dvs <= 32'h0;
      cnt <= 6'h0;
      busy <= 1'b0;
    end else if (div.start) begin
      rem <= 32'h0;
      quo <= div.dividend;
      dvs <= div.divisor;
      cnt <= `DCEMU_DIV_STEPS;
      busy <= 1'b1;
    end else if (busy) begin
      rem <= take ? diff[31:0] : shifted[31:0];
      quo <= {quo[30:0], take};
      cnt <= cnt - 6'h1;
      busy <= cnt != 6'h1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      done <= 1'b0;
    end else begin
      done <= busy && (cnt == 6'h1);
    end
  end

  assign div.done = done;
  assign div.quotient = quo;
  assign div.remainder = rem;
endmodule : dcemu_div

// [dv/dcemu_props.sv]
// port checker for the divide, compare, extend and accumulate slice
`timescale 1ns/10ps
module dcemu_props import dcemu_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_start,
  input wire dcemu_op_t i_op,
  input wire dcemu_size_t i_size,
  input wire logic i_ext_src_half,
  input wire logic [31:0] i_dst,
  input wire logic [31:0] i_src,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic [31:0] o_result,
  input wire logic o_result_we,
  input wire logic [3:0] o_flags,
  input wire logic o_flags_we,
  input wire logic [31:0] o_mac
);
  // --------------------
  // properties
  // --------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // a request is only taken while the divider is idle
  wire logic go = i_start && !o_busy;

  chk_div_latency: assert property ($rose(o_busy) |-> ##33 (o_done && !o_busy))
    else $error("divide did not finish 33 cycles after busy rose");
  chk_quick_done: assert property (go && i_op >= OP_COMPARE |=> o_done)
    else $error("single cycle operation did not complete");
  chk_cmp_no_write: assert property (go && i_op == OP_COMPARE |=> o_flags_we && !o_result_we)
    else $error("compare wrote its destination or skipped flags");
  chk_neg_value: assert property (go && i_op == OP_TWOS_COMPLEMENT && i_size == SZ_L
    |=> o_result == 32'h0 - $past(i_dst)) else $error("negate result wrong");
  chk_tas_msb: assert property (go && i_op == OP_TEST_AND_SET_MSB
    |=> o_result == ({24'h0, $past(i_dst[7:0])} | 32'h80)) else $error("test and set wrong");
  chk_clear_zero: assert property (go && i_op == OP_ACCUMULATOR_CLEAR |=> o_mac == 32'h0)
    else $error("accumulator not cleared");
  chk_load_copy: assert property (go && i_op == OP_ACCUMULATOR_LOAD |=> o_mac == $past(i_src))
    else $error("accumulator load wrong");
  chk_store_keep: assert property (go && i_op == OP_ACCUMULATOR_STORE
    |=> o_result_we && o_result == o_mac && $stable(o_mac)) else $error("store wrong");
  chk_zero_div: assert property (go && i_op == OP_UNSIGNED_DIVIDE_QUOTIENT_ONLY &&
    i_size == SZ_L && i_src == 32'h0 |=> o_done && o_flags == 4'h2 && o_result == $past(i_dst))
    else $error("zero divisor result wrong");

  cover property (go && i_op == OP_SIGNED_DIVIDE_WITH_REMAINDER);
  cover property (go && i_op == OP_MULTIPLY_ACCUMULATE);
  cover property (o_done && o_flags_we && o_flags[3]);
endmodule : dcemu_props

bind dcemu_top dcemu_props dcemu_props_inst (.i_core_clk, .i_rst_n, .i_start, .i_op, .i_size,
  .i_ext_src_half, .i_dst, .i_src, .o_busy, .o_done, .o_result, .o_result_we, .o_flags,
  .o_flags_we, .o_mac);

// [dv/dcemu_tb.sv]
// self-checking bench for the divide, compare, extend and accumulate slice
`timescale 1ns/10ps
module tb import dcemu_pkg::*; ;
  // --------------------
  // stimulus and checks
  // --------------------
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_start = 1'b0;
  dcemu_op_t i_op = OP_COMPARE;
  dcemu_size_t i_size = SZ_B;
  logic i_ext_src_half = 1'b0;
  logic [31:0] i_dst = 32'h0;
  logic [31:0] i_src = 32'h0;
  logic o_busy, o_done, o_result_we, o_flags_we;
  logic [31:0] o_result, o_mac;
  logic [3:0] o_flags;
  logic [31:0] exp_mac = 32'h0;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  integer seed = 43;

  always #50 i_core_clk = ~i_core_clk;

  dcemu_top dcemu_top_inst (.i_core_clk, .i_rst_n, .i_start, .i_op, .i_size, .i_ext_src_half,
    .i_dst, .i_src, .o_busy, .o_done, .o_result, .o_result_we, .o_flags, .o_flags_we, .o_mac);

  task automatic stop_test();
    $display("mismatches %0d of %0d checks", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic int wid(input logic [1:0] sz);
    return (sz == 2'h0) ? 8 : (sz == 2'h1) ? 16 : 32;
  endfunction : wid

  function automatic longint mk(input int n);
    return (longint'(1) <<< n) - 1;
  endfunction : mk

  function automatic longint sx(input longint x, input int n);
    return (x <<< (64 - n)) >>> (64 - n);
  endfunction : sx

  // returns {flags_we, result_we, flags, result}
  function automatic logic [37:0] model(input logic [3:0] op, input logic [1:0] sz,
      input logic h, input logic [31:0] d, input logic [31:0] s);
    int w, dw;
    longint a, b, q, r;
    logic [3:0] f;
    w = wid(sz);
    dw = (op == 4'h0 || op == 4'h2) ? 2 * w : w;
    a = d & mk(dw);
    b = s & mk(w);
    f = 4'h0;
    r = 0;
    if (op <= 4'h3) begin
      if (op[1]) begin
        a = sx(a, dw);
        b = sx(b, w);
      end
      if (b == 0) begin
        r = d & mk(dw);
        f = 4'h2;
      end else begin
        q = (a / b) & mk(w);
        r = op[0] ? q : (((a % b) & mk(w)) << w) | q;
        f = {q[w-1], q == 0, 2'b00};
      end
    end else if (op <= 4'h5) begin
      a = (op == 4'h4) ? d & mk(w) : 0;
      b = (op == 4'h4) ? s & mk(w) : d & mk(w);
      r = (a - b) & mk(w);
      f = {r[w-1], r == 0, a[w-1] != b[w-1] && r[w-1] != a[w-1], a < b};
    end else if (op <= 4'h7) begin
      dw = h ? 16 : 8;
      r = (op == 4'h6 ? d & mk(dw) : sx(d & mk(dw), dw)) & mk(w);
      f = {r[w-1], r == 0, 2'b00};
    end else if (op == 4'h8) begin
      r = d[7:0] | 8'h80;
      f = {d[7], d[7:0] == 8'h0, 2'b00};
    end else if (op == 4'hc) begin
      r = exp_mac;
    end
    return {op <= 4'h8, (op <= 4'h8 && op != 4'h4) || op == 4'hc, f, r[31:0]};
  endfunction : model

  task automatic run(input logic [3:0] op, input logic [1:0] sz, input logic h,
      input logic [31:0] d, input logic [31:0] s);
    logic [37:0] e;
    int n;
    logic slow;
    e = model(op, sz, h, d, s);
    slow = op <= 4'h3 && (s & mk(wid(sz))) != 0;
    @(posedge i_core_clk);
    i_start <= 1'b1;
    i_op <= dcemu_op_t'(op);
    i_size <= dcemu_size_t'(sz);
    i_ext_src_half <= h;
    i_dst <= d;
    i_src <= s;
    @(posedge i_core_clk);
    i_start <= 1'b0;
    n = 0;
    #1;
    chk(32'(o_busy), 32'(slow));
    while (o_done !== 1'b1 && n < 40) begin
      @(posedge i_core_clk);
      // a request while a divide runs must be ignored, else the count drifts
      i_start <= (n == 0) && slow;
      #1;
      n++;
    end
    if (op == 4'h9) exp_mac = exp_mac + 32'($signed(d[15:0])) * 32'($signed(s[15:0]));
    if (op == 4'ha) exp_mac = 32'h0;
    if (op == 4'hb) exp_mac = s;
    chk(32'(n), slow ? 32'h21 : 32'h0);
    chk(32'(o_busy), 32'h0);
    chk(32'(o_result_we), 32'(e[36]));
    chk(32'(o_flags_we), 32'(e[37]));
    if (e[36]) chk(o_result, e[31:0]);
    if (e[37]) chk(32'(o_flags), 32'(e[35:32]));
    chk(o_mac, exp_mac);
  endtask : run

  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles > 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  initial begin
    logic [3:0] op;
    logic [1:0] sz;
    logic h;
    logic [31:0] d, s;
    repeat (4) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    #1;
    chk(o_mac, 32'h0);
    run(4'h5, 2'h1, 1'b0, 32'h1, 32'h0);
    run(4'h0, 2'h1, 1'b0, 32'h64, 32'h7);
    for (int k = 0; k < 4; k++) run(k[3:0], 2'h1 + k[0], 1'b0, 32'h1234, 32'h0);
    run(4'h2, 2'h0, 1'b0, 32'hff9c, 32'h7);
    run(4'h3, 2'h2, 1'b0, 32'h8000_0000, 32'hffff_ffff);
    run(4'h8, 2'h0, 1'b0, 32'h0, 32'h0);
    run(4'hd, 2'h0, 1'b0, 32'h5, 32'h5);
    repeat (300) begin
      op = 4'($unsigned($random(seed)) % 13);
      sz = 2'($unsigned($random(seed)) % 3);
      h = 1'b0;
      if (op == 4'h0 || op == 4'h2) sz = {1'b0, sz[0]};
      if (op == 4'h1 || op == 4'h3 || op == 4'h6 || op == 4'h7) sz = sz[1] ? 2'h2 : 2'h1;
      if ((op == 4'h6 || op == 4'h7) && sz == 2'h2) h = 1'($random(seed));
      d = $random(seed);
      // shifting the divisor down gives many small and zero divisors
      s = $random(seed) >> ($unsigned($random(seed)) % 32);
      run(op, sz, h, d, s);
    end
    stop_test();
  end
endmodule : tb
